// ===== out46_regulation_cfg.sv
// Serial-accessed configuration register for outputs 4 to 6 and its setpoint decoder.
// Assumes serial pins arrive asynchronously and the core clock is at least eight times SCK;
// grouping and timed actuation status come from other logic on the core clock.
//
// Function
// - A frame whose six-bit address is 05h selects this register with its 16-bit data field.
// - Data bit 15 is output 6 regulation type and bits 14 to 11 its level code, MSB first.
// - Data bit 10 is output 5 regulation type and bits 9 to 6 its level code, MSB first.
// - Data bit 5 is output 4 (group two master) type, bits 4 to 1 its code, bit 0 parity.
// - In PWM type the duty is (code + 1) times 6.25 percent, from 6.25 to 100 percent.
// - A lone output in current type regulates to 1 A plus 0.2 A per code step, up to 4 A.
// - Two paralleled outputs regulate a total of 2 A plus 0.2 A times the sum of both codes.
// - Three paralleled outputs regulate a total of 3 A plus 0.2 A times the sum of all codes.
// - In current type each group member uses its own code and contributions add to one total.
// - In PWM type only the master code configures the group; the host sets equal types.
// - Writes are accepted any time but take effect only outside a timed actuation.
// - The register is readable and writable and a read returns the stored fields.
`timescale 1ns/1ps
module out46_regulation_cfg (
  // Clock and reset
  input  wire logic                        I_CORE_CLK,
  input  wire logic                        I_RESET,
  // Serial pins
  input  wire logic                        I_CSN,
  input  wire logic                        I_SCK,
  input  wire logic                        I_SDI,
  output logic                             O_SDO,
  output logic                             O_SDO_OE_N,
  // Grouping and actuation status
  input  wire logic                        I_GROUP_OUT5,
  input  wire logic                        I_GROUP_OUT6,
  input  wire logic                        I_TIMED_ACTUATION,
  // Setpoints
  output out46_reg_pkg::setpoint_t         O_OUT4_SETPOINT,
  output out46_reg_pkg::setpoint_t         O_OUT5_SETPOINT,
  output out46_reg_pkg::setpoint_t         O_OUT6_SETPOINT,
  output logic [6:0]                       O_GROUP_CURRENT_STEPS,
  output out46_reg_pkg::regulation_cfg_t   O_ACTIVE_CFG
);

  localparam int CNT_W = 5;

  // Two-flop synchronisers, plus a third stage for edge detection.
  logic [1:0] csn_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] sdi_sync_q;
  logic       sck_last_q;
  logic       csn_last_q;

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      csn_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      sdi_sync_q <= 2'h0;
      sck_last_q <= 1'b0;
      csn_last_q <= 1'b1;
    end else begin
      csn_sync_q <= {csn_sync_q[0], I_CSN};
      sck_sync_q <= {sck_sync_q[0], I_SCK};
      sdi_sync_q <= {sdi_sync_q[0], I_SDI};
      sck_last_q <= sck_sync_q[1];
      csn_last_q <= csn_sync_q[1];
    end
  end

  logic selected;
  logic sck_rise;
  logic sck_fall;
  logic csn_fall;
  logic csn_rise;

  assign selected = ~csn_sync_q[1];
  assign sck_rise = selected & sck_sync_q[1] & ~sck_last_q;
  assign sck_fall = selected & ~sck_sync_q[1] & sck_last_q;
  assign csn_fall = ~csn_sync_q[1] & csn_last_q;
  assign csn_rise = csn_sync_q[1] & ~csn_last_q;

  // Serial shifter state.
  logic [out46_reg_pkg::FRAME_BITS-1:0] rx_q, rx_d;
  logic [CNT_W-1:0]                     cnt_q, cnt_d;
  logic [out46_reg_pkg::DATA_BITS-1:0]  tx_q, tx_d;
  logic                                 sdo_q, sdo_d;
  out46_reg_pkg::regulation_cfg_t       shadow_q, shadow_d;
  out46_reg_pkg::regulation_cfg_t       active_q, active_d;

  logic [out46_reg_pkg::OP_BITS-1:0]    frame_op;
  logic [out46_reg_pkg::ADDR_BITS-1:0]  frame_addr;
  logic [out46_reg_pkg::DATA_BITS-1:0]  readback;

  // Header fields sit in the low byte once eight bits are in.
  assign frame_op   = rx_q[7:6];
  assign frame_addr = rx_q[5:0];

  // Parity is neither stored nor generated by the framing logic, so a read shifts it out as zero.
  assign readback = {shadow_q, 1'b0};

  always_comb begin
    rx_d     = rx_q;
    cnt_d    = cnt_q;
    tx_d     = tx_q;
    sdo_d    = sdo_q;
    shadow_d = shadow_q;
    if (csn_fall) begin
      cnt_d = '0;
      sdo_d = 1'b0;
    end else if (sck_rise) begin
      rx_d = {rx_q[out46_reg_pkg::FRAME_BITS-2:0], sdi_sync_q[1]};
      if (cnt_q <= CNT_W'(out46_reg_pkg::FRAME_BITS)) begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end else if (sck_fall) begin
      if (cnt_q == CNT_W'(out46_reg_pkg::HEAD_BITS)) begin
        if (frame_op == out46_reg_pkg::OP_READ &&
            frame_addr == out46_reg_pkg::OUTPUTS_4_TO_6_REGULATION_CONFIG_ADDR) begin
          tx_d  = {readback[out46_reg_pkg::DATA_BITS-2:0], 1'b0};
          sdo_d = readback[out46_reg_pkg::DATA_BITS-1];
        end else begin
          tx_d  = '0;
          sdo_d = 1'b0;
        end
      end else if (cnt_q > CNT_W'(out46_reg_pkg::HEAD_BITS)) begin
        sdo_d = tx_q[out46_reg_pkg::DATA_BITS-1];
        tx_d  = {tx_q[out46_reg_pkg::DATA_BITS-2:0], 1'b0};
      end
    end else if (!selected) begin
      // A read cut short must not leave a stale bit on the line once it is released.
      sdo_d = 1'b0;
    end
    // Only a frame of exactly 24 clocks commits, so a truncated frame cannot corrupt it.
    if (csn_rise && cnt_q == CNT_W'(out46_reg_pkg::FRAME_BITS) &&
        rx_q[23:22] == out46_reg_pkg::OP_WRITE &&
        rx_q[21:16] == out46_reg_pkg::OUTPUTS_4_TO_6_REGULATION_CONFIG_ADDR) begin
      shadow_d.out6_regulation_type = rx_q[out46_reg_pkg::OUT6_TYPE_POS];
      shadow_d.out6_level_code      = rx_q[out46_reg_pkg::OUT6_CODE_LSB+:4];
      shadow_d.out5_regulation_type = rx_q[out46_reg_pkg::OUT5_TYPE_POS];
      shadow_d.out5_level_code      = rx_q[out46_reg_pkg::OUT5_CODE_LSB+:4];
      shadow_d.out4_regulation_type = rx_q[out46_reg_pkg::OUT4_TYPE_POS];
      shadow_d.out4_level_code      = rx_q[out46_reg_pkg::OUT4_CODE_LSB+:4];
    end
    // The live copy is frozen for the whole actuation and refreshed between actuations.
    active_d = I_TIMED_ACTUATION ? active_q : shadow_q;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      rx_q     <= '0;
      cnt_q    <= '0;
      tx_q     <= '0;
      sdo_q    <= 1'b0;
      shadow_q <= out46_reg_pkg::CFG_RESET;
      active_q <= out46_reg_pkg::CFG_RESET;
    end else begin
      rx_q     <= rx_d;
      cnt_q    <= cnt_d;
      tx_q     <= tx_d;
      sdo_q    <= sdo_d;
      shadow_q <= shadow_d;
      active_q <= active_d;
    end
  end

  assign O_SDO        = sdo_q;
  assign O_SDO_OE_N   = csn_sync_q[1];
  assign O_ACTIVE_CFG = active_q;

  // Duty in sixteenths of full scale.
  function automatic logic [4:0] duty_of(input logic [3:0] code);
    duty_of = {1'b0, code} + 5'h01;
  endfunction

  // Current contribution of one output in 0.2 A steps.
  function automatic logic [6:0] current_of(input logic [3:0] code);
    current_of = out46_reg_pkg::CURRENT_BASE_STEPS + {3'h0, code};
  endfunction

  // Setpoint decode state.
  out46_reg_pkg::setpoint_t sp4_q, sp4_d;
  out46_reg_pkg::setpoint_t sp5_q, sp5_d;
  out46_reg_pkg::setpoint_t sp6_q, sp6_d;
  logic [6:0]               group_q, group_d;

  always_comb begin
    logic [3:0] code5_eff;
    logic [3:0] code6_eff;
    logic       type5_eff;
    logic       type6_eff;
    code5_eff = active_q.out5_level_code;
    code6_eff = active_q.out6_level_code;
    type5_eff = active_q.out5_regulation_type;
    type6_eff = active_q.out6_regulation_type;
    // In PWM the master's code drives every member of the group.
    if (active_q.out4_regulation_type == out46_reg_pkg::REG_TYPE_PWM) begin
      if (I_GROUP_OUT5) begin
        code5_eff = active_q.out4_level_code;
        type5_eff = out46_reg_pkg::REG_TYPE_PWM;
      end
      if (I_GROUP_OUT6) begin
        code6_eff = active_q.out4_level_code;
        type6_eff = out46_reg_pkg::REG_TYPE_PWM;
      end
    end
    sp4_d = '{active_q.out4_regulation_type, duty_of(active_q.out4_level_code),
              current_of(active_q.out4_level_code)};
    sp5_d = '{type5_eff, duty_of(code5_eff), current_of(code5_eff)};
    sp6_d = '{type6_eff, duty_of(code6_eff), current_of(code6_eff)};
    // Each grouped member adds its base step and its own code to the master's.
    group_d = current_of(active_q.out4_level_code);
    if (I_GROUP_OUT5) begin
      group_d = group_d + current_of(active_q.out5_level_code);
    end
    if (I_GROUP_OUT6) begin
      group_d = group_d + current_of(active_q.out6_level_code);
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      sp4_q   <= '{out46_reg_pkg::REG_TYPE_CURRENT, 5'h01, out46_reg_pkg::CURRENT_BASE_STEPS};
      sp5_q   <= '{out46_reg_pkg::REG_TYPE_CURRENT, 5'h01, out46_reg_pkg::CURRENT_BASE_STEPS};
      sp6_q   <= '{out46_reg_pkg::REG_TYPE_CURRENT, 5'h01, out46_reg_pkg::CURRENT_BASE_STEPS};
      group_q <= out46_reg_pkg::CURRENT_BASE_STEPS;
    end else begin
      sp4_q   <= sp4_d;
      sp5_q   <= sp5_d;
      sp6_q   <= sp6_d;
      group_q <= group_d;
    end
  end

  assign O_OUT4_SETPOINT       = sp4_q;
  assign O_OUT5_SETPOINT       = sp5_q;
  assign O_OUT6_SETPOINT       = sp6_q;
  assign O_GROUP_CURRENT_STEPS = group_q;

endmodule

// ===== out46_reg_pkg.sv
// Constants and types for the output 4 to 6 regulation configuration register.
// Assumes a 24-bit serial frame: two op bits, six address bits, sixteen data bits, MSB first.
package out46_reg_pkg;

  // Frame layout.
  localparam int FRAME_BITS   = 24;
  localparam int OP_BITS      = 2;
  localparam int ADDR_BITS    = 6;
  localparam int DATA_BITS    = 16;
  localparam int HEAD_BITS    = OP_BITS + ADDR_BITS;

  // Register address and operation codes.
  localparam logic [5:0] OUTPUTS_4_TO_6_REGULATION_CONFIG_ADDR = 6'h05;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ  = 2'h1;

  // Field positions within the 16-bit data word.
  localparam int OUT6_TYPE_POS = 15;
  localparam int OUT6_CODE_LSB = 11;
  localparam int OUT5_TYPE_POS = 10;
  localparam int OUT5_CODE_LSB = 6;
  localparam int OUT4_TYPE_POS = 5;
  localparam int OUT4_CODE_LSB = 1;
  localparam int PARITY_POS    = 0;

  // Regulation type encoding.
  localparam logic REG_TYPE_CURRENT = 1'b0;
  localparam logic REG_TYPE_PWM     = 1'b1;

  // Current setpoints are in 0.2 A steps; one output contributes 1 A at code 0.
  localparam logic [6:0] CURRENT_BASE_STEPS = 7'h05;

  // Field values as stored; the parity bit is not held.
  typedef struct packed {
    logic       out6_regulation_type;
    logic [3:0] out6_level_code;
    logic       out5_regulation_type;
    logic [3:0] out5_level_code;
    logic       out4_regulation_type;
    logic [3:0] out4_level_code;
  } regulation_cfg_t;

  localparam regulation_cfg_t CFG_RESET = '0;

  // Setpoint presented to one output stage.
  typedef struct packed {
    logic       regulation_type;
    logic [4:0] duty_sixteenths;
    logic [6:0] current_steps;
  } setpoint_t;

endpackage

// ===== out46_regulation_cfg_props.sv
// Checker for the regulation register ports.
// Assumes one core clock domain and the asynchronous active-high reset.
`timescale 1ns/1ps
module out46_regulation_cfg_props (
  // Watched ports
  input wire logic                      I_CORE_CLK,
  input wire logic                      I_RESET,
  input wire logic                      I_CSN,
  input wire logic                      O_SDO,
  input wire logic                      O_SDO_OE_N,
  input wire logic                      I_GROUP_OUT5,
  input wire logic                      I_GROUP_OUT6,
  input wire logic                      I_TIMED_ACTUATION,
  input out46_reg_pkg::setpoint_t       O_OUT4_SETPOINT,
  input out46_reg_pkg::setpoint_t       O_OUT5_SETPOINT,
  input logic [6:0]                     O_GROUP_CURRENT_STEPS,
  input out46_reg_pkg::regulation_cfg_t O_ACTIVE_CFG
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  logic [1:0] gv;
  assign gv = {I_GROUP_OUT6, I_GROUP_OUT5};
  a_oe_idle: assert property (I_CSN [*4] |-> O_SDO_OE_N)
    else $error("data out enabled while deselected");
  a_oe_drive: assert property (!I_CSN [*4] |-> !O_SDO_OE_N)
    else $error("data out not enabled in frame");
  a_sdo_quiet: assert property (O_SDO_OE_N |-> !O_SDO)
    else $error("data out high while released");
  a_active_frozen: assert property ($past(I_TIMED_ACTUATION) |-> $stable(O_ACTIVE_CFG))
    else $error("active copy moved in actuation");
  a_duty_code: assert property (O_OUT4_SETPOINT.duty_sixteenths ==
    5'h01 + $past(O_ACTIVE_CFG.out4_level_code)) else $error("duty wrong");
  a_out4_steps: assert property (O_OUT4_SETPOINT.current_steps ==
    7'h05 + $past(O_ACTIVE_CFG.out4_level_code)) else $error("steps wrong");
  a_out4_type: assert property (O_OUT4_SETPOINT.regulation_type ==
    $past(O_ACTIVE_CFG.out4_regulation_type)) else $error("type wrong");
  a_group_sum: assert property (gv == $past(gv) && gv == $past(gv, 2) |->
    O_GROUP_CURRENT_STEPS == 7'h05 + $past(O_ACTIVE_CFG.out4_level_code)
    + (gv[0] ? 7'h05 + $past(O_ACTIVE_CFG.out5_level_code) : 7'h00)
    + (gv[1] ? 7'h05 + $past(O_ACTIVE_CFG.out6_level_code) : 7'h00))
    else $error("group total wrong");
  a_out5_lone: assert property (!I_GROUP_OUT5 && !$past(I_GROUP_OUT5) |->
    O_OUT5_SETPOINT.current_steps == 7'h05 + $past(O_ACTIVE_CFG.out5_level_code))
    else $error("lone steps wrong");
  c_full: cover property (O_OUT4_SETPOINT.regulation_type && O_GROUP_CURRENT_STEPS == 7'h3C);
  c_freeze: cover property (I_TIMED_ACTUATION && !O_SDO_OE_N);
  c_read: cover property (O_SDO);
endmodule
bind out46_regulation_cfg out46_regulation_cfg_props u_props (
  .I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .I_CSN(I_CSN), .O_SDO(O_SDO),
  .O_SDO_OE_N(O_SDO_OE_N), .I_GROUP_OUT5(I_GROUP_OUT5), .I_GROUP_OUT6(I_GROUP_OUT6),
  .I_TIMED_ACTUATION(I_TIMED_ACTUATION), .O_OUT4_SETPOINT(O_OUT4_SETPOINT),
  .O_OUT5_SETPOINT(O_OUT5_SETPOINT), .O_GROUP_CURRENT_STEPS(O_GROUP_CURRENT_STEPS),
  .O_ACTIVE_CFG(O_ACTIVE_CFG));

// ===== spi_host.sv
// Serial host model that drives frames into the register block.
// Assumes it is stepped on falling core clock edges by the bench.
`timescale 1ns/1ps
module spi_host (
  // Core clock
  input  wire logic i_clk,
  // Serial pins
  output logic      o_csn,
  output logic      o_sck,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  initial begin
    o_csn = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end
  // Four core cycles per phase give the 200 ns link period; the clock rests low between frames.
  task automatic frame(input logic [23:0] w, output logic [15:0] r);
    r = 16'h0000;
    for (int i = 23; i >= 0; i--) begin
      o_csn = 1'b0;
      o_sdi = w[i];
      repeat (4) @(negedge i_clk);
      o_sck = 1'b1;
      r = {r[14:0], i_sdo};
      repeat (4) @(negedge i_clk);
      o_sck = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_csn = 1'b1;
    // A released data line must not keep looking valid.
    o_sdi = ~o_sdi;
    repeat (4) @(negedge i_clk);
  endtask
  // Sends only the first n bits of a frame, then releases select; n must be 1 to 24.
  task automatic cut(input logic [23:0] w, input int n);
    for (int i = 23; i > 23 - n; i--) begin
      o_csn = 1'b0;
      o_sdi = w[i];
      repeat (4) @(negedge i_clk);
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sck = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_csn = 1'b1;
    o_sdi = ~o_sdi;
    repeat (4) @(negedge i_clk);
  endtask
endmodule

// ===== test_output_regulation_setpoint_4to6.sv
// Self-checking bench for the output 4 to 6 regulation register.
// Assumes the serial host model and the bound checker.
`timescale 1ns/1ps
module test_output_regulation_setpoint_4to6;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic g5 = 1'b0;
  logic g6 = 1'b0;
  logic act = 1'b0;
  logic csn, sck, sdi, sdo, oe_n;
  logic [15:0] d, rv;
  logic [6:0] grp;
  out46_reg_pkg::setpoint_t s4, s5, s6;
  out46_reg_pkg::regulation_cfg_t cfg;
  int fail_count = 0;
  int checked = 0;
  logic [15:0] q[$];
  event rd_ev;
  always #12.5 clk = ~clk;
  spi_host host (.i_clk(clk), .o_csn(csn), .o_sck(sck), .o_sdi(sdi), .i_sdo(sdo));
  out46_regulation_cfg uut (.I_CORE_CLK(clk), .I_RESET(rst), .I_CSN(csn), .I_SCK(sck),
    .I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE_N(oe_n), .I_GROUP_OUT5(g5), .I_GROUP_OUT6(g6),
    .I_TIMED_ACTUATION(act), .O_OUT4_SETPOINT(s4), .O_OUT5_SETPOINT(s5),
    .O_OUT6_SETPOINT(s6), .O_GROUP_CURRENT_STEPS(grp), .O_ACTIVE_CFG(cfg));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [15:0] sp(input logic t, input logic [3:0] c);
    sp = t ? {t, 5'(c) + 5'h01} : {t, 7'(c) + 7'h05};
  endfunction
  function automatic logic [15:0] got(input out46_reg_pkg::setpoint_t s);
    got = s.regulation_type ? {1'b1, s.duty_sixteenths} : {1'b0, s.current_steps};
  endfunction
  task automatic wr(input logic [5:0] a, input logic [15:0] w);
    logic [15:0] r;
    host.frame({2'h0, a, w}, r);
    repeat (6) @(negedge clk);
  endtask
  task automatic rd(input logic [15:0] e);
    logic [15:0] r;
    q.push_back(e);
    host.frame({2'h1, 6'h05, 16'h0000}, r);
    rv = r;
    ->rd_ev;
  endtask
  always begin
    @(rd_ev);
    check(rv, q.pop_front());
  end
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'hD36E1F8C));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check({1'b0, cfg}, 16'h0000);
    check(got(s4), sp(1'b0, 4'h0));
    check(16'(oe_n), 16'h0001);
    rd(16'h0000);
    $display("end reset");
    for (int n = 0; n < 8; n++) begin
      d = n == 0 ? 16'hFFFF : n == 1 ? 16'h7BDE : 16'($urandom);
      {g6, g5} = n < 2 ? 2'h3 : 2'($urandom);
      if (g5) d[10] = d[5];
      if (g6) d[15] = d[5];
      wr(6'h05, d);
      check({1'b0, cfg}, {1'b0, d[15:1]});
      check(got(s4), sp(d[5], d[4:1]));
      check(got(s5), sp(d[10], (g5 && d[5]) ? d[4:1] : d[9:6]));
      check(got(s6), sp(d[15], (g6 && d[5]) ? d[4:1] : d[14:11]));
      check(grp, 7'h05 + d[4:1] + (g5 ? 7'h05 + d[9:6] : 7'h00)
        + (g6 ? 7'h05 + d[14:11] : 7'h00));
      rd(d & 16'hFFFE);
    end
    $display("end decode");
    wr(6'h06, ~d);
    check({1'b0, cfg}, {1'b0, d[15:1]});
    host.cut({2'h0, 6'h05, ~d}, 23);
    repeat (6) @(negedge clk);
    check({1'b0, cfg}, {1'b0, d[15:1]});
    $display("end address");
    act = 1'b1;
    wr(6'h05, ~d);
    check({1'b0, cfg}, {1'b0, d[15:1]});
    rd(~d & 16'hFFFE);
    act = 1'b0;
    repeat (3) @(negedge clk);
    check({1'b0, cfg}, {1'b0, ~d[15:1]});
    check(16'(q.size()), 16'h0000);
    $display("end actuation");
    test_done();
  end
endmodule
